// file: design/focr_pkg.sv
// Constants and carrier types for the flash operation address/command register bank.
// Assumes an AXI4-Lite master with 32-bit data; registers sit at four times their index.
package focr_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [15:0] IDX_COPYBACK_DEST = 16'hF103;
  localparam logic [15:0] IDX_SPARE_SLOT_A = 16'hF104;
  localparam logic [15:0] IDX_SPARE_SLOT_B = 16'hF105;
  localparam logic [15:0] IDX_SPARE_SLOT_C = 16'hF106;
  localparam logic [15:0] IDX_START_PAGE_SECTOR = 16'hF107;
  localparam logic [15:0] IDX_BUFFER_PLACEMENT = 16'hF200;
  localparam logic [15:0] IDX_OPERATION_COMMAND = 16'hF220;
  localparam logic [15:0] IDX_SYSTEM_CONFIG_ONE = 16'hF221;
  localparam logic [15:0] IDX_COMPLETION_STATUS = 16'hF230;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_ADDR_REG = 16'h0000;
  localparam logic [15:0] RST_COMMAND = 16'h0000;
  localparam logic [15:0] RST_SYSCFG = 16'h40C0;
  localparam logic RST_READY_FLAG = 1'b1;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PAGE_LSB = 2;
  localparam int BSEL_LSB = 8;
  localparam int BCNT_LSB = 0;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam logic [2:0] BRL_MIN_CODE = 3'h3;
  localparam logic [2:0] SECTORS_ON_ZERO = 3'h4;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [15:0] CMD_LOAD_MAIN = 16'h0000;
  localparam logic [15:0] CMD_LOAD_SPARE = 16'h0013;
  localparam logic [15:0] CMD_PROG_ALL = 16'h0080;
  localparam logic [15:0] CMD_PROG_SPARE = 16'h001A;
  localparam logic [15:0] CMD_COPYBACK = 16'h001B;
  localparam logic [15:0] CMD_UNLOCK = 16'h0023;
  localparam logic [15:0] CMD_LOCK = 16'h002A;
  localparam logic [15:0] CMD_LOCK_TIGHT = 16'h002C;
  localparam logic [15:0] CMD_ERASE_VERIFY = 16'h0071;
  localparam logic [15:0] CMD_ERASE_BLOCK = 16'h0094;
  localparam logic [15:0] CMD_ERASE_MULTI = 16'h0095;
  localparam logic [15:0] CMD_ERASE_SUSPEND = 16'h00B0;
  localparam logic [15:0] CMD_ERASE_RESUME = 16'h0030;
  localparam logic [15:0] CMD_CORE_RESET = 16'h00F0;
  localparam logic [15:0] CMD_HOT_RESET = 16'h00F3;
  localparam logic [15:0] CMD_OTP_ACCESS = 16'h0065;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic read_timing_select;
    logic [2:0] burst_latency_code;
    logic [2:0] burst_size_code;
    logic ecc_bypass;
    logic ready_pin_polarity;
    logic irq_pin_polarity;
    logic status_pin_drive_enable;
    logic ready_timing;
    logic [2:0] reserved;
    logic boot_buffer_lock_status;
  } focr_cfg_t;

  typedef struct packed {
    logic [15:0] cmd;
    logic [5:0] start_page_index;
    logic [1:0] start_sector_index;
    logic [5:0] copyback_dest_page;
    logic [1:0] copyback_dest_sector;
    logic [3:0] buffer_sector_select;
  } focr_core_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } focr_state_t;

endpackage

// file: design/focr_top.sv
// Flash operation address/command register bank with AXI4-Lite slave and operation sequencer.
// Assumes the flash core answers each sector or operation step with a one-cycle core_ack
// on mclk, and that it holds the block and OTP context outside this block.
//
// Notes on behaviour
// - Copy-back register bits 7:2 hold destination page, reset zero, upper bits zero.
// - Copy-back register bits 1:0 hold destination sector, reset zero.
// - Start register gives page bits 7:2 and sector bits 1:0 for transfers.
// - Sector count codes 1..3 mean that many sectors; code 0 means four.
// - Multi-sector steps bump only buffer select low bits, wrapping, upper bits fixed.
// - Buffer select bit 3 picks boot buffer or data buffers.
// - Buffer select bit 2 picks first or second data buffer.
// - Buffer select bits 1:0 give sector within chosen buffer.
// - Completion flag returns to ready when the operation finishes.
// - While busy only 00F0h/00F3h are accepted, and only for abortable operations.
// - 0000h loads main sectors, 0013h loads spare sectors into the buffer.
// - 0080h programs main and spare, 001Ah programs spare only.
// - 001Bh copy-back programs to destination page and sector registers.
// - 0023h/002Ah/002Ch unlock, lock, lock-tight a block; refused while busy.
// - 0071h, 0094h, 0095h, 00B0h, 0030h are erase operations; suspend refused busy.
// - 00F0h resets flash core only; 00F3h returns all registers to defaults too.
// - System configuration resets to 40C0h with documented field layout.
// - Configuration bit 15 selects asynchronous or synchronous burst reads.
// - Latency codes 3..7 give 3..7 cycles; codes 0..2 are not available.
// - Latency code sits in configuration bits 14:12.
`timescale 1ns/1ps
`default_nettype none

module focr_top #(
  parameter int ADDR_W = 18
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output focr_pkg::focr_core_op_t core_op,
  output logic core_req,
  input wire logic core_ack,
  output logic core_reset,
  output focr_pkg::focr_cfg_t cfg
);
  import focr_pkg::*;

  // ****************************************
  // Write channel capture
  // ****************************************
  logic awready_q;
  logic wready_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [15:0] wr_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
  wire aw_hold_d = (aw_hold_q | aw_take) & ~do_write;
  wire w_hold_d = (w_hold_q | w_take) & ~do_write;
  wire bvalid_d = do_write | (bvalid_q & ~s_axi_bready);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
    end else begin
      awready_q <= ~aw_hold_d;
      wready_q <= ~w_hold_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      bvalid_q <= bvalid_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_idx_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        wr_idx_q <= s_axi_awaddr[17:2];
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] copyback_q;
  logic [7:0] start_q;
  logic [3:0] bsel_q;
  logic [1:0] bcnt_q;
  logic [15:0] command_q;
  focr_cfg_t cfg_q;
  logic ready_flag_q;
  focr_state_t state_q;
  focr_core_op_t op_q;
  logic [2:0] steps_q;
  logic core_req_q;
  logic core_reset_q;

  // Byte-lane merge of the 16 live bits; lanes 2 and 3 carry nothing
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] res;
    res = old;
    if (st[0]) begin
      res[7:0] = wd[7:0];
    end
    if (st[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  wire hit_copyback = wr_idx_q == IDX_COPYBACK_DEST;
  wire hit_start = wr_idx_q == IDX_START_PAGE_SECTOR;
  wire hit_bplace = wr_idx_q == IDX_BUFFER_PLACEMENT;
  wire hit_cmd = wr_idx_q == IDX_OPERATION_COMMAND;
  wire hit_cfg = wr_idx_q == IDX_SYSTEM_CONFIG_ONE;
  wire hit_stat = wr_idx_q == IDX_COMPLETION_STATUS;
  wire hit_spare = (wr_idx_q == IDX_SPARE_SLOT_A) | (wr_idx_q == IDX_SPARE_SLOT_B) |
                   (wr_idx_q == IDX_SPARE_SLOT_C);
  wire wr_mapped = hit_copyback | hit_start | hit_bplace | hit_cmd | hit_cfg | hit_stat |
                   hit_spare;

  wire [15:0] bplace_now = {4'h0, bsel_q, 6'h00, bcnt_q};
  wire [15:0] wr_copyback = merge16({8'h00, copyback_q}, wdata_q, wstrb_q);
  wire [15:0] wr_start = merge16({8'h00, start_q}, wdata_q, wstrb_q);
  wire [15:0] wr_bplace = merge16(bplace_now, wdata_q, wstrb_q);
  wire [15:0] wr_cmd = merge16(command_q, wdata_q, wstrb_q);
  wire [15:0] wr_cfg = merge16(cfg_q, wdata_q, wstrb_q);
  wire [15:0] wr_stat = merge16({14'h0000, state_q != ST_IDLE, ready_flag_q}, wdata_q, wstrb_q);

  // ****************************************
  // Command decode and acceptance
  // ****************************************
  wire idle = state_q == ST_IDLE;
  wire code_is_transfer = (wr_cmd == CMD_LOAD_MAIN) | (wr_cmd == CMD_LOAD_SPARE) |
                          (wr_cmd == CMD_PROG_ALL) | (wr_cmd == CMD_PROG_SPARE) |
                          (wr_cmd == CMD_COPYBACK);
  wire code_is_single = (wr_cmd == CMD_UNLOCK) | (wr_cmd == CMD_LOCK) |
                        (wr_cmd == CMD_LOCK_TIGHT) | (wr_cmd == CMD_ERASE_VERIFY) |
                        (wr_cmd == CMD_ERASE_BLOCK) | (wr_cmd == CMD_ERASE_MULTI) |
                        (wr_cmd == CMD_ERASE_SUSPEND) | (wr_cmd == CMD_ERASE_RESUME) |
                        (wr_cmd == CMD_OTP_ACCESS);
  wire code_is_reset = (wr_cmd == CMD_CORE_RESET) | (wr_cmd == CMD_HOT_RESET);
  // Lock family and erase suspend are not abortable, so resets are refused while they run
  wire running_abortable = (op_q.cmd != CMD_UNLOCK) & (op_q.cmd != CMD_LOCK) &
                           (op_q.cmd != CMD_LOCK_TIGHT) & (op_q.cmd != CMD_ERASE_SUSPEND);
  wire cmd_write = do_write & hit_cmd;
  wire cmd_ok = idle ? (code_is_transfer | code_is_single | code_is_reset) :
                (code_is_reset & running_abortable);
  wire cmd_accept = cmd_write & cmd_ok;
  wire op_start = cmd_accept & ~code_is_reset;
  wire reset_cmd = cmd_accept & code_is_reset;
  wire hot_reset = cmd_accept & (wr_cmd == CMD_HOT_RESET);
  wire op_finish = (state_q == ST_DONE) | reset_cmd;
  wire reg_write = do_write & ~hot_reset;

  // ****************************************
  // Address, placement and command registers
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      copyback_q <= RST_ADDR_REG[7:0];
      start_q <= RST_ADDR_REG[7:0];
      bsel_q <= RST_ADDR_REG[11:8];
      bcnt_q <= RST_ADDR_REG[1:0];
      command_q <= RST_COMMAND;
    end else if (hot_reset) begin
      copyback_q <= RST_ADDR_REG[7:0];
      start_q <= RST_ADDR_REG[7:0];
      bsel_q <= RST_ADDR_REG[11:8];
      bcnt_q <= RST_ADDR_REG[1:0];
      command_q <= RST_COMMAND;
    end else begin
      if (reg_write & hit_copyback) begin
        copyback_q <= wr_copyback[7:0];
      end
      if (reg_write & hit_start) begin
        start_q <= wr_start[7:0];
      end
      if (reg_write & hit_bplace) begin
        bsel_q <= wr_bplace[BSEL_LSB+3:BSEL_LSB];
        bcnt_q <= wr_bplace[BCNT_LSB+1:BCNT_LSB];
      end
      if (cmd_accept) begin
        command_q <= wr_cmd;
      end
    end
  end

  // ****************************************
  // System configuration
  // ****************************************
  // Reserved bits and the boot lock status stay zero whatever is written
  focr_cfg_t cfg_wr;
  always_comb begin
    cfg_wr = focr_cfg_t'(wr_cfg);
    cfg_wr.reserved = 3'h0;
    cfg_wr.boot_buffer_lock_status = 1'b0;
    if (cfg_wr.burst_latency_code < BRL_MIN_CODE) begin
      cfg_wr.burst_latency_code = cfg_q.burst_latency_code;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= focr_cfg_t'(RST_SYSCFG);
    end else if (hot_reset) begin
      cfg_q <= focr_cfg_t'(RST_SYSCFG);
    end else if (reg_write & hit_cfg) begin
      cfg_q <= cfg_wr;
    end
  end

  // ****************************************
  // Completion flag
  // ****************************************
  // Completion wins over a simultaneous host clear so no finish is lost
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ready_flag_q <= RST_READY_FLAG;
    end else if (op_finish) begin
      ready_flag_q <= 1'b1;
    end else if (do_write & hit_stat & wstrb_q[0] & ~wr_stat[STAT_READY_BIT]) begin
      ready_flag_q <= 1'b0;
    end
  end

  // ****************************************
  // Operation sequencer
  // ****************************************
  wire [1:0] cnt_code = bcnt_q;
  wire [2:0] sector_total = (cnt_code == 2'h0) ? SECTORS_ON_ZERO : {1'b0, cnt_code};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      op_q <= '0;
      steps_q <= 3'h0;
      core_req_q <= 1'b0;
      core_reset_q <= 1'b0;
    end else begin
      core_reset_q <= reset_cmd;
      if (reset_cmd) begin
        state_q <= ST_IDLE;
        core_req_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (op_start) begin
              op_q.cmd <= wr_cmd;
              op_q.start_page_index <= start_q[7:PAGE_LSB];
              op_q.start_sector_index <= start_q[1:0];
              op_q.copyback_dest_page <= copyback_q[7:PAGE_LSB];
              op_q.copyback_dest_sector <= copyback_q[1:0];
              op_q.buffer_sector_select <= bsel_q;
              steps_q <= code_is_transfer ? sector_total : 3'h1;
              state_q <= ST_ISSUE;
            end
          end
          ST_ISSUE: begin
            core_req_q <= 1'b1;
            state_q <= ST_WAIT;
          end
          ST_WAIT: begin
            if (core_ack) begin
              core_req_q <= 1'b0;
              op_q.buffer_sector_select[1:0] <= op_q.buffer_sector_select[1:0] + 2'h1;
              steps_q <= steps_q - 3'h1;
              state_q <= (steps_q == 3'h1) ? ST_DONE : ST_ISSUE;
            end
          end
          ST_DONE: begin
            state_q <= ST_IDLE;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  wire ar_take = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire [15:0] rd_idx = s_axi_araddr[17:2];
  wire rd_spare = (rd_idx == IDX_SPARE_SLOT_A) | (rd_idx == IDX_SPARE_SLOT_B) |
                  (rd_idx == IDX_SPARE_SLOT_C);
  wire [15:0] rd_word =
    (rd_idx == IDX_COPYBACK_DEST) ? {8'h00, copyback_q} :
    (rd_idx == IDX_START_PAGE_SECTOR) ? {8'h00, start_q} :
    (rd_idx == IDX_BUFFER_PLACEMENT) ? bplace_now :
    (rd_idx == IDX_OPERATION_COMMAND) ? command_q :
    (rd_idx == IDX_SYSTEM_CONFIG_ONE) ? cfg_q :
    (rd_idx == IDX_COMPLETION_STATUS) ? {14'h0000, ~idle, ready_flag_q} : 16'h0000;
  wire rd_mapped = rd_spare | (rd_idx == IDX_COPYBACK_DEST) |
                   (rd_idx == IDX_START_PAGE_SECTOR) | (rd_idx == IDX_BUFFER_PLACEMENT) |
                   (rd_idx == IDX_OPERATION_COMMAND) | (rd_idx == IDX_SYSTEM_CONFIG_ONE) |
                   (rd_idx == IDX_COMPLETION_STATUS);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      bresp_q <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= {16'h0000, rd_word};
        rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (do_write) begin
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign core_op = op_q;
  assign core_req = core_req_q;
  assign core_reset = core_reset_q;
  assign cfg = cfg_q;

endmodule

`default_nettype wire

// file: test/focr_core_model.sv
// Flash core stand-in: answers each step request with a one-cycle acknowledge.
// Assumes the same clock as the bank; the bench sets the answer delay per scenario.
`timescale 1ns/1ps
`default_nettype none
module focr_core_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic core_req,
  input wire logic [7:0] ack_delay,
  output logic core_ack,
  output logic [7:0] steps
);
  logic [7:0] wait_q;
  // Never acknowledges without a pending request, just as the real core
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 8'h00;
      core_ack <= 1'b0;
      steps <= 8'h00;
    end else begin
      core_ack <= 1'b0;
      if (core_req && !core_ack) begin
        if (wait_q >= ack_delay) begin
          core_ack <= 1'b1;
          wait_q <= 8'h00;
          steps <= steps + 8'h01;
        end else begin
          wait_q <= wait_q + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: test/focr_monitor.sv
// Port-level checks of the register bank and its core step link.
// Assumes it is bound to focr_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module focr_monitor
  import focr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic s_axi_bvalid,
  input wire focr_pkg::focr_core_op_t core_op,
  input wire logic core_req,
  input wire logic core_ack,
  input wire logic core_reset,
  input wire focr_pkg::focr_cfg_t cfg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Ack, one idle cycle, then the next step of the same transfer
  sequence s_step_gap;
    core_req && core_ack ##2 core_req;
  endsequence
  property p_bsel_wrap;
    s_step_gap |-> core_op.buffer_sector_select[1:0] ==
      $past(core_op.buffer_sector_select[1:0], 2) + 2'h1;
  endproperty
  a_bsel_wrap: assert property (p_bsel_wrap)
    else $error("sector select did not advance by one");
  property p_bsel_upper;
    s_step_gap |-> core_op.buffer_sector_select[3:2] ==
      $past(core_op.buffer_sector_select[3:2], 2);
  endproperty
  a_bsel_upper: assert property (p_bsel_upper)
    else $error("buffer choice moved during a transfer");
  property p_ack_drop;
    core_req && core_ack |=> !core_req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("step request held after acknowledge");
  property p_reset_pulse;
    core_reset |=> !core_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("core reset longer than one cycle");
  property p_abort_idle;
    core_reset |-> ##[0:3] !core_req;
  endproperty
  a_abort_idle: assert property (p_abort_idle)
    else $error("step request survived a reset command");
  // A command taken while busy would move the running operation's fields
  property p_busy_cmd;
    core_req |-> $stable(core_op[35:4]);
  endproperty
  a_busy_cmd: assert property (p_busy_cmd)
    else $error("operation fields moved while busy");
  property p_cfg_reset;
    $rose(reset_n) |-> cfg == RST_SYSCFG;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("configuration not at default after reset");
  property p_cfg_zero;
    cfg.reserved == 3'h0 && !cfg.boot_buffer_lock_status;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero)
    else $error("read-only configuration bits not zero");
  property p_cfg_latency;
    cfg.burst_latency_code >= BRL_MIN_CODE;
  endproperty
  a_cfg_latency: assert property (p_cfg_latency)
    else $error("unavailable latency code stored");
  // Only a completed bus write may move the configuration
  property p_cfg_bus;
    $changed(cfg) |-> $rose(s_axi_bvalid);
  endproperty
  a_cfg_bus: assert property (p_cfg_bus)
    else $error("configuration changed without a write");
endmodule
bind focr_top focr_monitor u_focr_monitor (
  .mclk(mclk),
  .reset_n(reset_n),
  .s_axi_bvalid(s_axi_bvalid),
  .core_op(core_op),
  .core_req(core_req),
  .core_ack(core_ack),
  .core_reset(core_reset),
  .cfg(cfg)
);
`default_nettype wire

// file: test/test_flash_op_address_command_regs.sv
// Self-checking bench for the register bank, with the core model on its step link.
// Assumes focr_top, focr_core_model and the bound monitor are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_flash_op_address_command_regs;
  import focr_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, data;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, core_req, core_ack, core_reset;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] ack_delay = 8'h00, steps;
  focr_core_op_t core_op;
  focr_cfg_t cfg;
  int fail_count = 0, compares = 0, resets = 0;
  // Rows: index, written, read back, response
  localparam logic [49:0] ROWS [8] = '{{16'hF103, 16'hFFFF, 16'h00FF, 2'h0},
    {16'hF107, 16'h12A7, 16'h00A7, 2'h0}, {16'hF104, 16'h1234, 16'h0000, 2'h0},
    {16'hF200, 16'hFFFF, 16'h0F03, 2'h0}, {16'hF221, 16'h0000, 16'h4000, 2'h0},
    {16'hF221, 16'hB1F9, 16'hB1F0, 2'h0}, {16'hF221, 16'h40C0, 16'h40C0, 2'h0},
    {16'h0001, 16'hFFFF, 16'h0000, 2'h2}};
  localparam logic [31:0] RSTS [6] = '{32'hF103_0000, 32'hF107_0000, 32'hF200_0000,
    32'hF220_0000, 32'hF221_40C0, 32'hF230_0001};
  localparam logic [15:0] CMDS [14] = '{CMD_LOAD_MAIN, CMD_LOAD_SPARE, CMD_PROG_ALL,
    CMD_PROG_SPARE, CMD_COPYBACK, CMD_UNLOCK, CMD_LOCK, CMD_LOCK_TIGHT, CMD_ERASE_VERIFY,
    CMD_ERASE_BLOCK, CMD_ERASE_MULTI, CMD_ERASE_SUSPEND, CMD_ERASE_RESUME, CMD_OTP_ACCESS};
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    if (core_reset === 1'b1) begin
      resets++;
    end
  end
  focr_top u_focr_top (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_op(core_op), .core_req(core_req),
    .core_ack(core_ack), .core_reset(core_reset), .cfg(cfg));
  focr_core_model u_focr_core_model (.mclk(mclk), .reset_n(reset_n),
    .core_req(core_req), .ack_delay(ack_delay), .core_ack(core_ack), .steps(steps));
  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, output logic [1:0] r);
    logic aw_open, w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge mclk);
      if (aw_open && awready) begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready) begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // Spare edge so the next transfer never re-drives a signal in this step
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic run_op(input logic [15:0] cmd, input logic [1:0] buffer_sector_count, input logic [7:0] n);
    logic [7:0] s0;
    wr(IDX_BUFFER_PLACEMENT, {4'h0, 4'hD, 6'h00, buffer_sector_count}, resp);
    wr(IDX_COMPLETION_STATUS, 16'h0000, resp);
    s0 = steps;
    wr(IDX_OPERATION_COMMAND, cmd, resp);
    do rd(IDX_COMPLETION_STATUS, data, resp); while (data[0] !== 1'b1);
    chk(data, 32'h0000_0001);
    chk({24'h000000, steps - s0}, {24'h000000, n});
    rd(IDX_OPERATION_COMMAND, data, resp);
    chk(data, {16'h0000, cmd});
    chk(core_op[35:4], {cmd, ROWS[1][9:2], ROWS[0][9:2]});
    chk(32'(core_op[3:0]), {28'h0000000, 2'b11, 2'(n + 8'h01)});
  endtask
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      rd(RSTS[i][31:16], data, resp);
      chk(data, {16'h0000, RSTS[i][15:0]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(ROWS[i][49:34], ROWS[i][33:18], resp);
      chk({30'h0, resp}, {30'h0, ROWS[i][1:0]});
      rd(ROWS[i][49:34], data, resp);
      chk(data, {16'h0000, ROWS[i][17:2]});
      chk({30'h0, resp}, {30'h0, ROWS[i][1:0]});
    end
    // Transfers take the count from the sector field; code zero means four
    for (int i = 0; i < 14; i++) begin
      ack_delay <= 8'(i % 3);
      run_op(CMDS[i], 2'(i % 4), (i > 4) ? 8'h01 : ((i % 4 == 0) ? 8'h04 : 8'(i % 4)));
    end
    ack_delay <= 8'd60;
    wr(IDX_BUFFER_PLACEMENT, 16'h0400, resp);
    wr(IDX_COMPLETION_STATUS, 16'h0000, resp);
    wr(IDX_OPERATION_COMMAND, CMD_PROG_ALL, resp);
    wr(IDX_OPERATION_COMMAND, CMD_UNLOCK, resp);
    wr(IDX_OPERATION_COMMAND, CMD_ERASE_SUSPEND, resp);
    rd(IDX_OPERATION_COMMAND, data, resp);
    chk(data, {16'h0000, CMD_PROG_ALL});
    rd(IDX_COMPLETION_STATUS, data, resp);
    chk(data, 32'h0000_0002);
    wr(IDX_OPERATION_COMMAND, CMD_CORE_RESET, resp);
    rd(IDX_COMPLETION_STATUS, data, resp);
    chk(data, 32'h0000_0001);
    chk(resets, 1);
    wr(IDX_SYSTEM_CONFIG_ONE, 16'hB1F0, resp);
    wr(IDX_COPYBACK_DEST, 16'h0055, resp);
    wr(IDX_OPERATION_COMMAND, CMD_HOT_RESET, resp);
    rd(IDX_SYSTEM_CONFIG_ONE, data, resp);
    chk(data, {16'h0000, RST_SYSCFG});
    rd(IDX_COPYBACK_DEST, data, resp);
    chk(data, 32'h0000_0000);
    chk(resets, 2);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
